// ### hdl/rpa_pkg.sv
package rpa_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices; the byte address is four times the index
   localparam logic [9:0] IDX_DET_EN    = 10'h020;
   localparam logic [9:0] IDX_BLK_LEN   = 10'h021;
   localparam logic [9:0] IDX_THR_HI_L  = 10'h022;
   localparam logic [9:0] IDX_THR_HI_H  = 10'h023;
   localparam logic [9:0] IDX_THR_LO_L  = 10'h024;
   localparam logic [9:0] IDX_THR_LO_H  = 10'h025;
   localparam logic [9:0] IDX_FMT       = 10'h027;
   localparam logic [9:0] IDX_AGC_RST   = 10'h02b;
   localparam logic [9:0] IDX_SEL_P4    = 10'h032;
   localparam logic [9:0] IDX_SEL_P1    = 10'h033;
   localparam logic [9:0] IDX_SEL_P3    = 10'h034;
   localparam logic [9:0] IDX_SEL_P2    = 10'h035;
   localparam logic [9:0] IDX_PIN_DIR   = 10'h037;
   localparam logic [9:0] IDX_IRQ_STAT  = 10'h040;
   localparam logic [9:0] IDX_IRQ_MASK  = 10'h041;
   localparam logic [9:0] IDX_FLAGS     = 10'h042;

   ////////////////////////////////////////////////////////////////////////
   // field positions and widths
   localparam int unsigned AGC_RST_BIT  = 4;
   localparam int unsigned EXP_W        = 5;
   localparam int unsigned THR_W        = 16;
   localparam int unsigned DIR_BIT_P1   = 1;
   localparam int unsigned DIR_BIT_P2   = 3;
   localparam int unsigned DIR_BIT_P3   = 2;
   localparam int unsigned DIR_BIT_P4   = 0;
   localparam int unsigned NUM_PINS     = 4;
   localparam int unsigned NUM_EVENTS   = 4;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_THR      = 16'h0000;
   localparam logic [4:0]  RST_EXP      = 5'h00;

   ////////////////////////////////////////////////////////////////////////
   // pin source codes
   localparam logic [7:0]  SRC_IIR0_HI  = 8'h01;
   localparam logic [7:0]  SRC_RMS0     = 8'h06;
   localparam logic [7:0]  SRC_PER_CH   = 8'h09;
   localparam logic [7:0]  SRC_LAST     = 8'h11;

   ////////////////////////////////////////////////////////////////////////
   // bus answers
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // detector inputs of one channel, one beat per fs/8 cycle
   typedef struct packed {
      logic [15:0] sample;
      logic        valid;
      logic [1:0]  iir0_flag;
      logic [1:0]  iir1_flag;
      logic        iir0_two_bit;
      logic        iir1_two_bit;
      logic        blk_peak_hi;
      logic        blk_peak_lo;
      logic        fast_ovr;
   } rpa_chan_in_type;

endpackage : rpa_pkg

// ### hdl/rpa_rms_det.sv
`timescale 1ns/100ps
`default_nettype none

module rpa_rms_det #(
   parameter int unsigned MAX_EXP = 16
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     srst,
   // settings
   input  wire logic                     run,
   input  wire logic                     two_bit,
   input  wire logic [rpa_pkg::EXP_W-1:0] exp_len,
   input  wire logic [rpa_pkg::THR_W-1:0] thr_hi,
   input  wire logic [rpa_pkg::THR_W-1:0] thr_lo,
   // samples
   input  wire logic [15:0]              sample,
   input  wire logic                     valid,
   // results
   output logic      [1:0]               flags,
   output logic                          done,
   output logic                          rise
);
   import rpa_pkg::*;

   logic [16:0]       cnt_reg;
   logic [32:0]       acc_reg;
   logic              hyst_reg;
   logic              above_reg;
   logic [EXP_W-1:0]  exp_c;
   logic [16:0]       last;
   logic signed [31:0] sq;
   logic [15:0]       pwr;
   logic [32:0]       acc_sum;
   logic [15:0]       avg;
   logic              block_end;

   ////////////////////////////////////////////////////////////////////////
   // power as an unsigned fraction, full scale saturates to all ones
   assign exp_c   = (exp_len > EXP_W'(MAX_EXP)) ? EXP_W'(MAX_EXP) : exp_len;
   assign last    = (17'h1 << exp_c) - 17'h1;
   assign sq      = signed'(sample) * signed'(sample);
   assign pwr     = sq[30] ? 16'hffff : sq[29:14];
   assign acc_sum = acc_reg + {17'h0, pwr};
   assign avg     = 16'(acc_sum >> exp_c);
   assign block_end = run && valid && (cnt_reg == last);

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         cnt_reg <= 17'h0;
         acc_reg <= 33'h0;
      end else if (valid) begin
         if (block_end) begin
            cnt_reg <= 17'h0;
            acc_reg <= 33'h0;
         end else begin
            cnt_reg <= cnt_reg + 17'h1;
            acc_reg <= acc_sum;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !run) begin
         hyst_reg  <= 1'b0;
         above_reg <= 1'b0;
         done      <= 1'b0;
         rise      <= 1'b0;
      end else begin
         done <= block_end;
         rise <= block_end && (avg > thr_hi) && !hyst_reg;
         if (block_end) begin
            above_reg <= avg > thr_hi;
            if (avg > thr_hi)
               hyst_reg <= 1'b1;
            else if (avg < thr_lo)
               hyst_reg <= 1'b0;
         end
      end
   end

   // upper bit only exists in two-bit format
   assign flags = {two_bit & above_reg, hyst_reg};

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   blk_len_a: assert property (done |-> $past(valid) &&
         $past(cnt_reg) == $past(last))
      else $error("block ended at wrong count");
   hyst_set_a: assert property (block_end && avg > thr_hi
         |=> hyst_reg && flags[0])
      else $error("flag not set above high threshold");
   hyst_clr_a: assert property (block_end && avg < thr_lo
         && !(avg > thr_hi) |=> !hyst_reg)
      else $error("flag not cleared below low threshold");
   fmt_one_a: assert property (!two_bit |-> flags[1] == 1'b0)
      else $error("upper flag bit set in one-bit format");

endmodule : rpa_rms_det

`default_nettype wire

// ### hdl/rpa_top.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - average power over 2^M fs/8 beats, M from 5-bit field, 0..16
// - compare each average with 16-bit high and low threshold registers
// - threshold LSB is 1/2^16 of full-scale power, unsigned fraction
// - one flag bit when two-bit enable is 0, flag pair when 1
// - detectors held in reset while gain-loop reset bit is 1
// - per-pin 8-bit source select, codes 0..8 pick channel A flags
// - codes 9..17 pick the same nine sources from channel B
// - upper bit of a flag pair driven only in two-bit format
// - power detector runs only while its enable bit is 1
// - pin driven with its source only when its direction bit is 1
module rpa_top (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // axi4-lite write address and data
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // axi4-lite write response
   output logic      [1:0]              s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // detector inputs
   input  wire rpa_pkg::rpa_chan_in_type chan_a,
   input  wire rpa_pkg::rpa_chan_in_type chan_b,
   // alarm pins, index 0 is pin 1
   input  wire logic [3:0]              pin_in,
   output logic      [3:0]              pin_out,
   output logic      [3:0]              pin_oe,
   // interrupt
   output logic                         irq
);
   import rpa_pkg::*;

   logic              det_en_reg;
   logic [EXP_W-1:0]  exp_reg;
   logic [15:0]       thr_hi_reg;
   logic [15:0]       thr_lo_reg;
   logic              two_bit_reg;
   logic              agc_rst_reg;
   logic [7:0]        sel_reg [NUM_PINS];
   logic [3:0]        dir_reg;
   logic [NUM_EVENTS-1:0] stat_reg;
   logic [NUM_EVENTS-1:0] mask_reg;
   logic [NUM_EVENTS-1:0] ev;
   logic [3:0]        pin_dir;
   logic [3:0]        s1_reg, s2_reg, s3_reg, pin_in_reg;
   logic [1:0]        rms_a, rms_b;
   logic              done_a, done_b, rise_a, rise_b;
   logic              run;
   logic [8:0]        src_a, src_b;
   logic              aw_full_reg, w_full_reg, w_en_reg;
   logic [9:0]        aw_idx_reg;
   logic [7:0]        w_byte_reg;
   logic              wr_fire, wr_en;
   logic [31:0]       rd_value;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic reg_known(input logic [9:0] idx);
      unique case (idx)
         IDX_DET_EN, IDX_BLK_LEN, IDX_THR_HI_L, IDX_THR_HI_H,
         IDX_THR_LO_L, IDX_THR_LO_H, IDX_FMT, IDX_AGC_RST,
         IDX_SEL_P4, IDX_SEL_P1, IDX_SEL_P3, IDX_SEL_P2,
         IDX_PIN_DIR, IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_FLAGS:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction : reg_known

   // nine sources of one channel, indexed by source code
   function automatic logic [8:0] pack_src(input rpa_chan_in_type c,
                                           input logic [1:0] rms);
      return {c.fast_ovr, rms, c.blk_peak_lo, c.blk_peak_hi,
              c.iir1_flag[1] & c.iir1_two_bit, c.iir1_flag[0],
              c.iir0_flag[1] & c.iir0_two_bit,
              c.iir0_flag[0]};
   endfunction : pack_src

   function automatic logic pick(input logic [7:0] code,
                                 input logic [8:0] va,
                                 input logic [8:0] vb);
      logic [7:0] b_code;
      b_code = code - SRC_PER_CH;
      if (code < SRC_PER_CH)
         return va[code[3:0]];
      else if (code <= SRC_LAST)
         return vb[b_code[3:0]];
      else
         return 1'b0;
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave, address and data taken in either order

   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready  = !w_full_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_en   = wr_fire && w_en_reg && reg_known(aw_idx_reg);

   always_ff @(posedge clk) begin
      if (srst) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         w_en_reg     <= 1'b0;
         aw_idx_reg   <= 10'h0;
         w_byte_reg   <= RST_BYTE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[11:2];
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_en_reg   <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_known(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= reg_known(s_axi_araddr[11:2]) ? RESP_OKAY
                                                         : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // reserved bits read as zero
   always_comb begin
      rd_value = 32'h0;
      unique case (s_axi_araddr[11:2])
         IDX_DET_EN:   rd_value[0]       = det_en_reg;
         IDX_BLK_LEN:  rd_value[4:0]     = exp_reg;
         IDX_THR_HI_L: rd_value[7:0]     = thr_hi_reg[7:0];
         IDX_THR_HI_H: rd_value[7:0]     = thr_hi_reg[15:8];
         IDX_THR_LO_L: rd_value[7:0]     = thr_lo_reg[7:0];
         IDX_THR_LO_H: rd_value[7:0]     = thr_lo_reg[15:8];
         IDX_FMT:      rd_value[0]       = two_bit_reg;
         IDX_AGC_RST:  rd_value[AGC_RST_BIT] = agc_rst_reg;
         IDX_SEL_P1:   rd_value[7:0]     = sel_reg[0];
         IDX_SEL_P2:   rd_value[7:0]     = sel_reg[1];
         IDX_SEL_P3:   rd_value[7:0]     = sel_reg[2];
         IDX_SEL_P4:   rd_value[7:0]     = sel_reg[3];
         IDX_PIN_DIR:  rd_value[3:0]     = dir_reg;
         IDX_IRQ_STAT: rd_value[3:0]     = stat_reg;
         IDX_IRQ_MASK: rd_value[3:0]     = mask_reg;
         IDX_FLAGS:    rd_value[7:0]     = {pin_in_reg, rms_b, rms_a};
         default:      rd_value          = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration; only defined fields are stored

   always_ff @(posedge clk) begin
      if (srst) begin
         det_en_reg  <= 1'b0;
         exp_reg     <= RST_EXP;
         thr_hi_reg  <= RST_THR;
         thr_lo_reg  <= RST_THR;
         two_bit_reg <= 1'b0;
         agc_rst_reg <= 1'b0;
         dir_reg     <= 4'h0;
         mask_reg    <= 4'h0;
         for (int i = 0; i < NUM_PINS; i++)
            sel_reg[i] <= RST_BYTE;
      end else if (wr_en) begin
         unique case (aw_idx_reg)
            IDX_DET_EN:   det_en_reg  <= w_byte_reg[0];
            IDX_BLK_LEN:  exp_reg     <= w_byte_reg[4:0];
            IDX_THR_HI_L: thr_hi_reg[7:0]  <= w_byte_reg;
            IDX_THR_HI_H: thr_hi_reg[15:8] <= w_byte_reg;
            IDX_THR_LO_L: thr_lo_reg[7:0]  <= w_byte_reg;
            IDX_THR_LO_H: thr_lo_reg[15:8] <= w_byte_reg;
            IDX_FMT:      two_bit_reg <= w_byte_reg[0];
            IDX_AGC_RST:  agc_rst_reg <= w_byte_reg[AGC_RST_BIT];
            IDX_SEL_P1:   sel_reg[0]  <= w_byte_reg;
            IDX_SEL_P2:   sel_reg[1]  <= w_byte_reg;
            IDX_SEL_P3:   sel_reg[2]  <= w_byte_reg;
            IDX_SEL_P4:   sel_reg[3]  <= w_byte_reg;
            IDX_PIN_DIR:  dir_reg     <= w_byte_reg[3:0];
            IDX_IRQ_MASK: mask_reg    <= w_byte_reg[3:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // detectors, both channels share one setting

   assign run = det_en_reg && !agc_rst_reg;

   rpa_rms_det u_det_a (
      .clk     (clk),
      .srst    (srst),
      .run     (run),
      .two_bit (two_bit_reg),
      .exp_len (exp_reg),
      .thr_hi  (thr_hi_reg),
      .thr_lo  (thr_lo_reg),
      .sample  (chan_a.sample),
      .valid   (chan_a.valid),
      .flags   (rms_a),
      .done    (done_a),
      .rise    (rise_a)
   );

   rpa_rms_det u_det_b (
      .clk     (clk),
      .srst    (srst),
      .run     (run),
      .two_bit (two_bit_reg),
      .exp_len (exp_reg),
      .thr_hi  (thr_hi_reg),
      .thr_lo  (thr_lo_reg),
      .sample  (chan_b.sample),
      .valid   (chan_b.valid),
      .flags   (rms_b),
      .done    (done_b),
      .rise    (rise_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupts; a new event beats a clear in the same cycle

   assign ev = {done_b, done_a, rise_b, rise_a};

   always_ff @(posedge clk) begin
      if (srst)
         stat_reg <= 4'h0;
      else if (wr_en && aw_idx_reg == IDX_IRQ_STAT)
         stat_reg <= (stat_reg & ~w_byte_reg[3:0]) | ev;
      else
         stat_reg <= stat_reg | ev;
   end

   assign irq = |(stat_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // pins; inputs pass three flops, a level counts once s2 and s3 agree

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_reg     <= 4'h0;
         s2_reg     <= 4'h0;
         s3_reg     <= 4'h0;
         pin_in_reg <= 4'h0;
      end else begin
         s1_reg     <= pin_in;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         pin_in_reg <= (s2_reg & s3_reg) | (pin_in_reg & (s2_reg | s3_reg));
      end
   end

   assign pin_dir = {dir_reg[DIR_BIT_P4], dir_reg[DIR_BIT_P3],
                     dir_reg[DIR_BIT_P2], dir_reg[DIR_BIT_P1]};
   assign src_a   = pack_src(chan_a, rms_a);
   assign src_b   = pack_src(chan_b, rms_b);
   assign pin_oe  = pin_dir;

   always_ff @(posedge clk) begin
      if (srst)
         pin_out <= 4'h0;
      else
         for (int i = 0; i < NUM_PINS; i++)
            pin_out[i] <= pin_dir[i] && pick(sel_reg[i], src_a, src_b);
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence agc_pulse_s;
      agc_rst_reg ##1 !agc_rst_reg;
   endsequence

   agc_hold_a: assert property (agc_rst_reg |=> rms_a == 2'h0
         && !done_a && !done_b)
      else $error("detector active during gain-loop reset");
   // counters must come out of the gain-loop reset empty
   agc_release_a: assert property (agc_pulse_s |->
         u_det_a.cnt_reg == 17'h0 && u_det_b.cnt_reg == 17'h0)
      else $error("detector not cleared at gain-loop release");
   det_off_a: assert property (!det_en_reg |=> !done_a && !rise_b)
      else $error("detector ran while disabled");
   sel_chan_a_a: assert property (pin_dir[0] && sel_reg[0] == SRC_RMS0
         |=> pin_out[0] == $past(rms_a[0]))
      else $error("pin does not follow channel A flag");
   sel_chan_b_a: assert property (pin_dir[1]
         && sel_reg[1] == SRC_RMS0 + SRC_PER_CH
         |=> pin_out[1] == $past(rms_b[0]))
      else $error("pin does not follow channel B flag");
   upper_mask_a: assert property (sel_reg[0] == SRC_IIR0_HI
         && !chan_a.iir0_two_bit |=> !pin_out[0])
      else $error("upper flag bit driven in one-bit format");
   dir_input_a: assert property (!pin_dir[2] |-> !pin_oe[2]
         ##1 !pin_out[2])
      else $error("input pin driven");
   sticky_ev_a: assert property (ev[1] |=> stat_reg[1] [*2]
         or (stat_reg[1] ##1 $past(wr_en)))
      else $error("event lost from status");

endmodule : rpa_top

`default_nettype wire

// ### bench/rpa_agc_model.sv
`timescale 1ns/100ps
`default_nettype none

module rpa_agc_model (
   // pins seen by the gain loop
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   // level the loop puts on undriven pins
   input  wire logic [3:0] ext,
   output logic      [3:0] pin_in
);
   // a pin not driven by the block carries the far side level
   always_comb begin
      for (int i = 0; i < 4; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext[i];
   end
endmodule : rpa_agc_model

`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import rpa_pkg::*;
   logic             clk = 0;
   logic             srst = 1;
   logic [11:0]      s_axi_awaddr = 0, s_axi_araddr = 0;
   logic             s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic             s_axi_arvalid = 0;
   logic             s_axi_bready = 1, s_axi_rready = 1;
   logic [31:0]      s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]       s_axi_wstrb = 4'hf;
   logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic             s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]       s_axi_bresp, s_axi_rresp;
   rpa_chan_in_type  chan_a = '0, chan_b = '0;
   logic [3:0]       pin_in, pin_out, pin_oe, ext = 0;
   logic [33:0]      expq[$];
   logic [1:0]       bq[$];
   logic [31:0]      seed = 32'h7c42;
   logic [8:0]       v, m;
   int               err_total = 0, check_count = 0;
   logic [9:0]       regs[13] = '{IDX_DET_EN, IDX_BLK_LEN, IDX_THR_HI_L,
      IDX_THR_HI_H, IDX_THR_LO_L, IDX_THR_LO_H, IDX_FMT, IDX_AGC_RST,
      IDX_SEL_P4, IDX_SEL_P1, IDX_SEL_P3, IDX_SEL_P2, IDX_PIN_DIR};

   always #4 clk = ~clk;

   rpa_top uut (
      .clk(clk), .srst(srst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .chan_a(chan_a), .chan_b(chan_b),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   rpa_agc_model agc (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
                      .pin_in(pin_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   task automatic check(logic [33:0] got, logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic hang;
      err_total++;
      results();
   endtask : hang

   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   function automatic rpa_chan_in_type mk(logic [8:0] f, logic t);
      mk = '0;
      mk.iir0_flag = f[1:0];
      mk.iir1_flag = f[3:2];
      mk.blk_peak_hi = f[4];
      mk.blk_peak_lo = f[5];
      mk.fast_ovr = f[8];
      mk.iir0_two_bit = t;
      mk.iir1_two_bit = t;
   endfunction : mk

   ////////////////////////////////////////////////////////////////////////
   // start a cycle late so a lowered valid never rises in the same step
   task automatic wr(logic [9:0] idx, logic [7:0] d,
                     logic [1:0] er = RESP_OKAY);
      int n;
      bq.push_back(er);
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      if (n == 50) hang();
   endtask : wr

   task automatic rd(logic [9:0] idx, logic [7:0] d,
                     logic [1:0] er = RESP_OKAY);
      int n;
      expq.push_back({er, 24'h0, d});
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      if (n == 50) hang();
   endtask : rd

   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready && expq.size() > 0)
         check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
         check(34'(s_axi_bresp), 34'(bq.pop_front()));
   end

   // k sample beats, then time for the block result to land
   task automatic blk(logic [15:0] s, int k = 4);
      repeat (k) begin
         @(posedge clk);
         chan_a.sample <= s;
         chan_a.valid <= 1;
         chan_b.sample <= s;
         chan_b.valid <= 1;
         @(posedge clk);
         chan_a.valid <= 0;
         chan_b.valid <= 0;
      end
      repeat (3) @(posedge clk);
   endtask : blk

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      srst <= 0;
      foreach (regs[i]) rd(regs[i], 8'h00);
      rd(10'h030, 8'h00, RESP_SLVERR);
      wr(10'h030, 8'h55, RESP_SLVERR);
      // a write without the low byte lane must leave the register alone
      s_axi_wstrb <= 4'he;
      wr(IDX_SEL_P4, 8'h55);
      s_axi_wstrb <= 4'hf;
      rd(IDX_SEL_P4, 8'h00);
      $display("test registers ended");
      wr(IDX_PIN_DIR, 8'h0f);
      wr(IDX_SEL_P2, 8'h0f);
      for (int t = 0; t < 2; t++) begin
         // rms flags are idle here, upper pair bits need two-bit format
         m = {1'b1, 2'b00, 2'b11, t[0], 1'b1, t[0], 1'b1};
         for (int c = 0; c < 19; c++) begin
            seed = xs(seed);
            chan_a <= mk(seed[8:0], t[0]);
            chan_b <= mk(seed[17:9], t[0]);
            wr(IDX_SEL_P1, 8'(c));
            repeat (2) @(posedge clk);
            v = (c < 9) ? seed[8:0] : seed[17:9];
            check(34'(pin_out[0]), 34'(c < 18 && v[c%9] && m[c%9]));
            check(34'(pin_out[3:1]), 34'({{2{seed[0]}}, 1'b0}));
         end
      end
      check(34'(pin_oe), 34'h00f);
      wr(IDX_PIN_DIR, 8'h00);
      repeat (2) @(posedge clk);
      check(34'({pin_oe, pin_out}), 34'h0);
      $display("test pin select ended");
      ext <= 4'ha;
      wr(IDX_BLK_LEN, 8'h02);
      wr(IDX_THR_HI_H, 8'h20);
      wr(IDX_THR_LO_H, 8'h08);
      wr(IDX_FMT, 8'h01);
      wr(IDX_AGC_RST, 8'h10);
      wr(IDX_DET_EN, 8'h01);
      blk(16'h4000);
      rd(IDX_FLAGS, 8'ha0);
      wr(IDX_AGC_RST, 8'h00);
      blk(16'h4000);
      rd(IDX_FLAGS, 8'haf);
      blk(16'h2000);
      rd(IDX_FLAGS, 8'ha5);
      blk(16'h0000);
      rd(IDX_FLAGS, 8'ha0);
      wr(IDX_DET_EN, 8'h00);
      blk(16'h4000);
      rd(IDX_FLAGS, 8'ha0);
      wr(IDX_DET_EN, 8'h01);
      blk(16'h4000, 3);
      rd(IDX_FLAGS, 8'ha0);
      blk(16'h4000, 1);
      rd(IDX_FLAGS, 8'haf);
      $display("test detector ended");
      rd(IDX_IRQ_STAT, 8'h0f);
      check(34'(irq), 34'h0);
      wr(IDX_IRQ_MASK, 8'h01);
      check(34'(irq), 34'h1);
      wr(IDX_IRQ_STAT, 8'h01);
      check(34'(irq), 34'h0);
      wr(IDX_IRQ_MASK, 8'h04);
      check(34'(irq), 34'h1);
      wr(IDX_IRQ_STAT, 8'h04);
      check(34'(irq), 34'h0);
      $display("test interrupt ended");
      // let the monitor take the last answers before the verdict
      repeat (2) @(posedge clk);
      check(34'(expq.size() + bq.size()), 34'h0);
      results();
   end
endmodule : tb_top

`default_nettype wire
